// file: imp_host.sv
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "imp_params.svh"

module imp_host (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  imp_if.host              bus,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic      [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  imp_pkg::imp_host_st_t st_q;
  logic        aw_got_q;
  logic [3:0]  aw_addr_q;
  logic        w_got_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [15:0] wdata_reg_q;
  logic        req_q;
  logic        we_q;
  logic [7:0]  addr_q;
  logic [15:0] dwdata_q;
  logic [15:0] last_q;
  logic        vpend_q;
  logic [9:0]  vofs_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic  do_wr   = aw_got_q & w_got_q & ~bvalid_q;
  wire logic  busy    = st_q == imp_pkg::IMP_ST_BUSY;
  wire logic  hit_cmd = aw_addr_q == `IMP_AXI_CMD;
  wire logic  hit_wd  = aw_addr_q == `IMP_AXI_WDATA;
  // A command while busy is dropped, not queued
  // Strobes travel with the data beat, not with the live pins
  wire logic  start   = do_wr & hit_cmd & ~busy & w_strb_q[0];
  wire logic  cmd_we  = w_data_q[`IMP_CMD_WRITE_BIT];
  wire logic  cmd_eoi = w_data_q[7:0] == `IMP_OFS_EOI;
  // Slave end command carries the level only, upper bits zero
  wire logic [15:0] out_data =
      (bus.slave_mode & cmd_eoi) ? {13'h0000, wdata_reg_q[2:0]}
                                 : wdata_reg_q;
  wire logic  rd_take = s_axi_arvalid & ~rvalid_q;
  wire logic [3:0] ra = s_axi_araddr;
  wire logic  ra_ok   = (ra == `IMP_AXI_CMD) | (ra == `IMP_AXI_WDATA) |
                        (ra == `IMP_AXI_STATUS) | (ra == `IMP_AXI_VECOFS);
  wire logic [31:0] rd_mux =
      (ra == `IMP_AXI_WDATA)  ? {16'h0000, wdata_reg_q} :
      (ra == `IMP_AXI_STATUS) ? {busy, 15'h0000, last_q} :
      (ra == `IMP_AXI_VECOFS) ? {vpend_q, 21'h000000, vofs_q} :
      {23'h000000, we_q, addr_q};

  // Channels open until their item is held, and shut while a response waits
  assign s_axi_awready = ~aw_got_q & ~bvalid_q;
  assign s_axi_wready  = ~w_got_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;

  // ----------------------------------------------------------------
  // AXI write side; address and data may come in either order
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q    <= 1'b0;
      aw_addr_q   <= 4'h0;
      w_got_q     <= 1'b0;
      w_data_q    <= 32'h00000000;
      w_strb_q    <= 4'h0;
      bvalid_q    <= 1'b0;
      bresp_q     <= `IMP_RESP_OKAY;
      wdata_reg_q <= 16'h0000;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_got_q  <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= (hit_cmd | hit_wd) ? `IMP_RESP_OKAY : `IMP_RESP_SLVERR;
        if (hit_wd & w_strb_q[0]) begin
          wdata_reg_q[7:0] <= w_data_q[7:0];
        end
        if (hit_wd & w_strb_q[1]) begin
          wdata_reg_q[15:8] <= w_data_q[15:8];
        end
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI read side
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= `IMP_RESP_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= ra_ok ? rd_mux : 32'h00000000;
      rresp_q  <= ra_ok ? `IMP_RESP_OKAY : `IMP_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Device access sequencer; request held until the answer
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q     <= imp_pkg::IMP_ST_IDLE;
      req_q    <= 1'b0;
      we_q     <= 1'b0;
      addr_q   <= 8'h00;
      dwdata_q <= 16'h0000;
      last_q   <= 16'h0000;
    end else begin
      unique case (st_q)
        imp_pkg::IMP_ST_IDLE: begin
          if (start) begin
            st_q     <= imp_pkg::IMP_ST_BUSY;
            req_q    <= 1'b1;
            we_q     <= cmd_we;
            addr_q   <= w_data_q[7:0];
            dwdata_q <= out_data;
          end
        end
        imp_pkg::IMP_ST_BUSY: begin
          if (bus.ack) begin
            st_q   <= imp_pkg::IMP_ST_IDLE;
            req_q  <= 1'b0;
            last_q <= we_q ? last_q : bus.rdata;
          end
        end
      endcase
    end
  end

  // Table offset is the presented type times four
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vpend_q <= 1'b0;
      vofs_q  <= 10'h000;
    end else begin
      vpend_q <= bus.int_pending;
      vofs_q  <= {bus.int_type, 2'b00};
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus.req      = req_q;
  assign bus.we       = we_q;
  assign bus.addr     = addr_q;
  assign bus.wdata    = dwdata_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule

// file: imp_params.svh
`ifndef IMP_PARAMS_SVH
`define IMP_PARAMS_SVH

// ----------------------------------------------------------------
// Device register offsets, as printed
// ----------------------------------------------------------------
`define IMP_OFS_VECTOR   8'h20
`define IMP_OFS_EOI      8'h22
`define IMP_OFS_POLL     8'h24
`define IMP_OFS_PEEK     8'h26
`define IMP_OFS_BLOCK    8'h28

// ----------------------------------------------------------------
// Mask layout and reset values per mode
// ----------------------------------------------------------------
`define IMP_MST_BLOCK_RST  16'h07fd
`define IMP_SLV_BLOCK_RST  16'h003d
`define IMP_MST_IMPL       16'h07fd
`define IMP_SLV_IMPL       16'h003d

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IMP_PEND_BIT       15
`define IMP_NONSPEC_BIT    15
`define IMP_TYPE_HI        4
`define IMP_LEVEL_HI       2
`define IMP_VEC_HI         7
`define IMP_VEC_LO         3

// Master-mode type of source bit n is this base plus n
`define IMP_TYPE_BASE      5'h08

// ----------------------------------------------------------------
// Host command registers on AXI4-Lite
// ----------------------------------------------------------------
`define IMP_AXI_CMD        4'h0
`define IMP_AXI_WDATA      4'h4
`define IMP_AXI_STATUS     4'h8
`define IMP_AXI_VECOFS     4'hc
`define IMP_CMD_WRITE_BIT  8
`define IMP_STAT_BUSY_BIT  31
`define IMP_RESP_OKAY      2'b00
`define IMP_RESP_SLVERR    2'b10

`endif

// file: imp_pkg.sv
package imp_pkg;

  // Host sequencer states, Gray along idle -> busy -> idle
  typedef enum logic [0:0] {
    IMP_ST_IDLE = 1'b0,
    IMP_ST_BUSY = 1'b1
  } imp_host_st_t;

  typedef logic [15:0] imp_word_t;

endpackage

// file: imp_if.sv
`timescale 1ns/1ps

// Register port between the core side and the interrupt registers
interface imp_if;
  logic                 req;
  logic                 we;
  logic [7:0]           addr;
  imp_pkg::imp_word_t   wdata;
  imp_pkg::imp_word_t   rdata;
  logic                 ack;
  logic                 slave_mode;
  logic                 int_pending;
  logic [7:0]           int_type;

  modport dev (
    input  req,
    input  we,
    input  addr,
    input  wdata,
    output rdata,
    output ack,
    output slave_mode,
    output int_pending,
    output int_type
  );

  modport host (
    output req,
    output we,
    output addr,
    output wdata,
    input  rdata,
    input  ack,
    input  slave_mode,
    input  int_pending,
    input  int_type
  );
endinterface

// file: imp_device.sv
`timescale 1ns/1ps
`include "imp_params.svh"

// What this block does
// - Master mask read/write, 1 blocks source
// - Master mask bit layout, reserved bits
// - Master mask resets to 07fd
// - Slave mask layout mirrors control mask bits
// - Slave mask resets to 003d
// - Peek read returns poll, no side effect
// - Poll read acknowledges, next one presented
// - Bit 15 flags a pending interrupt
// - Bits 4-0 give highest pending type
// - End command write clears in-service flags
// - Master: bit 15 nonspecific, else type
// - Software ends service before interrupt return
// - Software prefers the specific end form
// - Slave: level bits 2-0, upper zero
// - Slave end command write-only, no reset
// - Slave vector holds upper five type bits
// - Core shifts type left two for offset
// - Vector needs no reset, software programs
// - Taken sets in-service until end command
module imp_device (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  imp_if.dev               bus,
  input  wire logic        slave_mode,
  input  wire logic [15:0] pending_flag,
  input  wire logic        take_valid,
  input  wire logic [3:0]  take_bit,
  input  wire logic        ctl_block_wr,
  input  wire logic [3:0]  ctl_block_bit,
  input  wire logic        ctl_block_val,
  output logic      [15:0] source_block,
  output logic      [15:0] in_service_flags,
  output logic      [15:0] poll_ack
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Lowest set bit wins; bit 0 is the highest priority
  function automatic logic [3:0] first_set(input logic [15:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [15:0] one_hot(input logic [3:0] n);
    return 16'h0001 << n;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] block_q;
  logic [15:0] block_d;
  logic [15:0] in_service_flags_q;
  logic [15:0] in_service_flags_d;
  logic [4:0]  vec_q;
  logic [4:0]  vec_d;
  logic        ack_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [15:0] poll_ack_q;
  logic        pend_q;
  logic [7:0]  type_q;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------

  // One access per request; the cycle of the answer takes none
  wire logic        acc      = bus.req & ~ack_q;
  wire logic        wr_acc   = acc & bus.we;
  wire logic        rd_acc   = acc & ~bus.we;
  wire logic        hit_vec  = (bus.addr == `IMP_OFS_VECTOR) & slave_mode;
  wire logic        hit_eoi  = bus.addr == `IMP_OFS_EOI;
  wire logic        hit_poll = bus.addr == `IMP_OFS_POLL;
  wire logic        hit_peek = bus.addr == `IMP_OFS_PEEK;
  wire logic        hit_blk  = bus.addr == `IMP_OFS_BLOCK;

  // Bits that exist in the present mode
  wire logic [15:0] impl = slave_mode ? `IMP_SLV_IMPL : `IMP_MST_IMPL;

  // ----------------------------------------------------------------
  // Pending selection
  // ----------------------------------------------------------------

  // Sources already in service are held back until ended
  wire logic [15:0] eligible = pending_flag & ~block_q & ~in_service_flags_q & impl;
  wire logic        any_pend = |eligible;
  wire logic [3:0]  top_bit  = first_set(eligible);
  wire logic [4:0]  mst_type = `IMP_TYPE_BASE + {1'b0, top_bit};
  // Slave: upper five from the vector, lower three from the level
  wire logic [7:0]  full_type = slave_mode ? {vec_q, top_bit[2:0]}
                                           : {3'h0, mst_type};
  // Flag on top, type in the low field, gap reads zero
  wire logic [15:0] poll_word = {any_pend, 10'h000,
                                 full_type[`IMP_TYPE_HI:0]};

  // Poll read acknowledges only when something is presented
  wire logic        poll_take = rd_acc & hit_poll & any_pend;

  // ----------------------------------------------------------------
  // End-of-service decode
  // ----------------------------------------------------------------
  wire logic        eoi_wr   = wr_acc & hit_eoi;
  wire logic        nonspec  = ~slave_mode & bus.wdata[`IMP_NONSPEC_BIT];
  wire logic [4:0]  spec_off = bus.wdata[`IMP_TYPE_HI:0] - `IMP_TYPE_BASE;
  // Types below the base wrap into the top half and match nothing
  wire logic        spec_ok  = ~spec_off[4];
  wire logic [3:0]  slv_bit  = {1'b0, bus.wdata[`IMP_LEVEL_HI:0]};
  wire logic [3:0]  ns_bit   = first_set(in_service_flags_q);
  wire logic [3:0]  clr_bit  = slave_mode ? slv_bit :
                               nonspec    ? ns_bit  : spec_off[3:0];
  wire logic        clr_ok   = slave_mode | (nonspec ? |in_service_flags_q : spec_ok);
  wire logic [15:0] clr_mask = (eoi_wr & clr_ok) ? one_hot(clr_bit)
                                                 : 16'h0000;
  wire logic [15:0] set_mask =
      (take_valid ? one_hot(take_bit) : 16'h0000) |
      (poll_take  ? one_hot(top_bit)  : 16'h0000);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------

  // A take in the same cycle as its end command still sets the flag
  assign in_service_flags_d = ((in_service_flags_q & ~clr_mask) | set_mask) & impl;

  // Software write beats a same-cycle control-register update
  always_comb begin
    block_d = block_q;
    if (wr_acc & hit_blk) begin
      block_d = bus.wdata & impl;
    end else if (ctl_block_wr) begin
      block_d[ctl_block_bit] = ctl_block_val;
    end
    block_d = block_d & impl;
  end

  // Only the five type bits are stored; the rest read zero
  assign vec_d = (wr_acc & hit_vec) ? bus.wdata[`IMP_VEC_HI:`IMP_VEC_LO]
                                    : vec_q;

  // Read mux; end command is write-only and reads zero
  always_comb begin
    rdata_d = rdata_q;
    if (rd_acc) begin
      rdata_d = 16'h0000;
      if (hit_poll | hit_peek) begin
        rdata_d = poll_word;
      end else if (hit_blk) begin
        rdata_d = block_q;
      end else if (hit_vec) begin
        rdata_d = {8'h00, vec_q, 3'h0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // Mask reset value follows the mode strap seen at reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_q <= slave_mode ? `IMP_SLV_BLOCK_RST
                            : `IMP_MST_BLOCK_RST;
      in_service_flags_q <= 16'h0000;
    end else begin
      block_q  <= block_d;
      in_service_flags_q <= in_service_flags_d;
    end
  end

  // Vector cleared anyway; software still must program it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vec_q <= 5'h00;
    end else begin
      vec_q <= vec_d;
    end
  end

  // Answer, read data and presented type
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ack_q      <= 1'b0;
      rdata_q    <= 16'h0000;
      poll_ack_q <= 16'h0000;
      pend_q     <= 1'b0;
      type_q     <= 8'h00;
    end else begin
      ack_q      <= acc;
      rdata_q    <= rdata_d;
      poll_ack_q <= poll_take ? one_hot(top_bit) : 16'h0000;
      pend_q     <= any_pend;
      type_q     <= full_type;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus.ack          = ack_q;
  assign bus.rdata        = rdata_q;
  assign bus.slave_mode   = slave_mode;
  assign bus.int_pending  = pend_q;
  assign bus.int_type     = type_q;
  assign source_block     = block_q;
  assign in_service_flags = in_service_flags_q;
  assign poll_ack         = poll_ack_q;

endmodule

// file: imp_checker_properties.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Register port checker, watches the joining interface
// ------------------------------------------------------------
module imp_checker (
  input logic               aclk,
  input logic               aresetn,
  input logic               req,
  input logic               we,
  input logic [7:0]         addr,
  input imp_pkg::imp_word_t wdata,
  input imp_pkg::imp_word_t rdata,
  input logic               ack,
  input logic               slave_mode,
  input logic               int_pending,
  input logic [7:0]         int_type
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Read answers seen in the ack cycle, address still held
  wire rd_ack = ack && !we;

  req_answer_a: assert property ($rose(req) |=> ack)
    else $error("ack not one cycle after request");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  req_hold_a: assert property (req && !ack |=> req && $stable(addr)
    && $stable(we) && $stable(wdata))
    else $error("request dropped or changed before ack");
  rdata_hold_a: assert property ($changed(rdata) |-> rd_ack)
    else $error("read data changed outside a read answer");
  poll_fields_a: assert property (rd_ack && (addr == 8'h24 ||
    addr == 8'h26) |-> rdata[14:5] == 10'h000)
    else $error("poll reserved bits not zero");
  mask_master_a: assert property (rd_ack && addr == 8'h28 &&
    !slave_mode |-> rdata[15:11] == 5'h00 && !rdata[1])
    else $error("master mask reserved bits set");
  mask_slave_a: assert property (rd_ack && addr == 8'h28 &&
    slave_mode |-> rdata[15:6] == 10'h000 && !rdata[1])
    else $error("slave mask reserved bits set");
  eoi_read_a: assert property (rd_ack && addr == 8'h22
    |-> rdata == 16'h0000)
    else $error("end command register not write-only");
  vec_fields_a: assert property (rd_ack && addr == 8'h20
    |-> rdata[15:8] == 8'h00 && rdata[2:0] == 3'h0)
    else $error("vector reserved bits set");
  type_master_a: assert property (int_pending && !slave_mode
    |-> int_type >= 8'h08 && int_type <= 8'h12 && int_type != 8'h09)
    else $error("master type outside implemented sources");
  type_slave_a: assert property (int_pending && slave_mode
    |-> int_type[2:0] inside {3'd0, 3'd2, 3'd3, 3'd4, 3'd5})
    else $error("slave level not an implemented source");

  // Main scenarios reached
  cover property (rd_ack && addr == 8'h24 && rdata[15]);
  cover property (slave_mode && int_pending);
  cover property (ack && we && addr == 8'h22 && wdata[15]);
endmodule

// file: interrupt_mask_poll_eoi_regs_tb.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Comparison helper
// ------------------------------------------------------------
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  mismatches++; $display("Error at %0t: got %h, want %h", \
  $time, (g), (e)); end end

module interrupt_mask_poll_eoi_regs_tb;
  logic        aclk = 0, aresetn = 0, slave_mode = 0;
  logic [15:0] pending_flag = 0, pa, r;
  logic        take_valid = 0, ctl_block_wr = 0, ctl_block_val = 0;
  logic [3:0]  take_bit = 0, ctl_block_bit = 0;
  logic [15:0] source_block, in_service_flags, poll_ack;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          mismatches = 0, comparisons = 0, cycles = 0;
  integer      seed = 32'h6a30;
  logic [33:0] exp_q[$];
  logic [31:0] msk_q[$];

  always #25 aclk = ~aclk;

  imp_if imp_if_inst ();
  imp_device imp_device_inst (.aclk(aclk), .aresetn(aresetn),
    .bus(imp_if_inst), .slave_mode(slave_mode),
    .pending_flag(pending_flag), .take_valid(take_valid),
    .take_bit(take_bit), .ctl_block_wr(ctl_block_wr),
    .ctl_block_bit(ctl_block_bit), .ctl_block_val(ctl_block_val),
    .source_block(source_block), .in_service_flags(in_service_flags),
    .poll_ack(poll_ack));
  imp_host imp_host_inst (.aclk(aclk), .aresetn(aresetn),
    .bus(imp_if_inst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));
  imp_checker imp_checker_inst (.aclk(aclk), .aresetn(aresetn),
    .req(imp_if_inst.req), .we(imp_if_inst.we),
    .addr(imp_if_inst.addr), .wdata(imp_if_inst.wdata),
    .rdata(imp_if_inst.rdata), .ack(imp_if_inst.ack),
    .slave_mode(imp_if_inst.slave_mode),
    .int_pending(imp_if_inst.int_pending),
    .int_type(imp_if_inst.int_type));

  task conclude;
    if (mismatches == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard; the whole run needs a few hundred cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  // ------------------------------------------------------------
  // Read monitor: oldest note against each read answer
  // ------------------------------------------------------------
  always @(negedge aclk) begin
    if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
      `CHK({s_axi_rresp, s_axi_rdata & msk_q[0]}, exp_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  // Handshakes judged at negedge, signals moved after the posedge
  task axi_wr(input logic [3:0] a, input logic [31:0] d,
              input logic [1:0] er);
    logic ha, hw, hb;
    hb = 0;
    @(posedge aclk);
    s_axi_awvalid <= 1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_bready  <= 1;
    while (!hb) begin
      @(negedge aclk);
      ha = s_axi_awvalid && s_axi_awready;
      hw = s_axi_wvalid && s_axi_wready;
      hb = s_axi_bvalid && s_axi_bready;
      if (hb) `CHK(s_axi_bresp, er)
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 0;
      if (hw) s_axi_wvalid <= 0;
      if (hb) s_axi_bready <= 0;
    end
  endtask

  task axi_rd(input logic [3:0] a, input logic [33:0] e,
              input logic [31:0] m);
    logic ha, h;
    h = 0;
    @(posedge aclk);
    exp_q.push_back({e[33:32], e[31:0] & m});
    msk_q.push_back(m);
    s_axi_arvalid <= 1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1;
    while (!h) begin
      @(negedge aclk);
      ha = s_axi_arvalid && s_axi_arready;
      h  = s_axi_rvalid && s_axi_rready;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 0;
      if (h) s_axi_rready <= 0;
    end
  endtask

  // Device access through the command registers, ends after ack
  task dev_op(input logic w, input logic [7:0] ofs, input logic [15:0] d);
    if (w) axi_wr(4'h4, {16'h0000, d}, 2'b00);
    axi_wr(4'h0, {23'h000000, w, ofs}, 2'b00);
    @(negedge aclk);
    while (!imp_if_inst.ack) @(negedge aclk);
    pa = poll_ack;
    @(posedge aclk);
  endtask

  task dev_rd(input logic [7:0] ofs, input logic [15:0] e);
    dev_op(0, ofs, 16'h0000);
    axi_rd(4'h8, {18'h00000, e}, 32'hffffffff);
  endtask

  task ctl(input logic [3:0] b, input logic v);
    ctl_block_wr  <= 1;
    ctl_block_bit <= b;
    ctl_block_val <= v;
    @(posedge aclk);
    ctl_block_wr  <= 0;
  endtask

  task rst(input logic sm);
    slave_mode <= sm;
    aresetn    <= 0;
    repeat (5) @(posedge aclk);
    aresetn    <= 1;
  endtask

  // ------------------------------------------------------------
  // Main sequence: master mode, then slave mode after reset
  // ------------------------------------------------------------
  initial begin
    rst(0);
    dev_rd(8'h28, 16'h07fd);
    dev_op(1, 8'h28, 16'hffff);
    dev_rd(8'h28, 16'h07fd);
    r = 16'($random(seed));
    dev_op(1, 8'h28, r);
    dev_rd(8'h28, r & 16'h07fd);
    ctl(4'd4, ~r[4]);
    dev_rd(8'h28, (r & 16'h07fd) ^ 16'h0010);
    `CHK(source_block, (r & 16'h07fd) ^ 16'h0010)
    dev_op(1, 8'h20, 16'hffff);
    dev_rd(8'h20, 16'h0000);
    dev_rd(8'h22, 16'h0000);
    dev_rd(8'h2a, 16'h0000);
    axi_rd(4'h2, {2'b10, 32'h0}, 32'hffffffff);
    axi_wr(4'h8, 32'h0, 2'b10);
    dev_op(1, 8'h28, 16'h0000);
    pending_flag <= 16'h0214;
    dev_rd(8'h26, 16'h800a);
    dev_rd(8'h26, 16'h800a);
    `CHK(in_service_flags, 16'h0000)
    dev_rd(8'h24, 16'h800a);
    `CHK(pa, 16'h0004)
    `CHK(in_service_flags, 16'h0004)
    axi_rd(4'hc, {2'b00, 32'h80000030}, 32'h800003ff);
    dev_rd(8'h26, 16'h800c);
    dev_op(1, 8'h22, 16'h000a);
    `CHK(in_service_flags, 16'h0000)
    dev_rd(8'h24, 16'h800a);
    dev_rd(8'h24, 16'h800c);
    `CHK(in_service_flags, 16'h0014)
    dev_op(1, 8'h22, 16'h8000);
    `CHK(in_service_flags, 16'h0010)
    take_valid <= 1;
    take_bit   <= 4'd9;
    @(posedge aclk);
    take_valid <= 0;
    @(negedge aclk);
    `CHK(in_service_flags, 16'h0210)
    dev_op(1, 8'h22, 16'h0011);
    `CHK(in_service_flags, 16'h0010)
    rst(1);
    pending_flag <= 16'h0008;
    dev_rd(8'h28, 16'h003d);
    dev_op(1, 8'h28, 16'hffff);
    dev_rd(8'h28, 16'h003d);
    ctl(4'd5, 1'b0);
    dev_rd(8'h28, 16'h001d);
    dev_op(1, 8'h20, 16'hffff);
    dev_rd(8'h20, 16'h00f8);
    dev_op(1, 8'h28, 16'h0000);
    dev_rd(8'h26, 16'h801b);
    axi_rd(4'hc, {2'b00, 32'h800003ec}, 32'h800003ff);
    dev_rd(8'h24, 16'h801b);
    `CHK(in_service_flags, 16'h0008)
    dev_op(1, 8'h22, 16'h0001);
    `CHK(in_service_flags, 16'h0008)
    r = 16'($random(seed));
    dev_op(1, 8'h22, {r[15:3], 3'd3});
    `CHK(in_service_flags, 16'h0000)
    conclude();
  end
endmodule
